// file: hdl/cdt_decode.sv
// Instruction decoder and cycle sequencer of the accumulator core.
//
// Functional notes
// (RULE_01) Code-space reads take three cycles.
// (RULE_02) External-data moves take three cycles, 8/16-bit address.
// (RULE_03) Carry/zero jumps take two or three cycles.
// (RULE_04) Bit jumps 3/4; test-and-clear clears set bit.
// (RULE_05) Compare-branch 3/4, indirect form 4/5.
// (RULE_06) Decrement-branch: register 2/3, direct 3/4.
// (RULE_07) Short call 3, long call 4 cycles.
// (RULE_08) Both returns take five cycles.
// (RULE_09) Jumps: short 3, long 4, relative 3, indirect 3.
// (RULE_10) Relative offset signed, from next instruction.
// (RULE_11) Short targets stay in next instruction's page.
// (RULE_12) Direct below 0x80 is RAM, else SFR.
// (RULE_13) Registers from active bank; indirect uses first two.
// (RULE_14) Unused opcode behaves as one-cycle no-operation.
// (RULE_15) Register moves 1, indirect 2, direct-direct 3.
// (RULE_16) Data pointer immediate load: three bytes, three cycles.
// (RULE_17) Push and pop: two bytes, two cycles.
// (RULE_18) Nibble exchange swaps low nibble, two cycles.
// (RULE_19) Accumulator clear/complement/swap/rotates single cycle.
// (RULE_20) Carry ops 1 cycle; bit logic 2 cycles.
// (RULE_21) Long targets take the full 16-bit field.
// (RULE_22) Bank chosen by two status-word bits.
// (RULE_23) Taken branch flushes prefetched byte first; only taken conditional branches flush here, jumps, calls and returns do not.
`timescale 1ns/100ps
module cdt_decode (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             insn_valid,
  input  wire cdt_pkg::cdt_insn_t insn,
  output logic                  insn_ready,
  output cdt_pkg::cdt_dec_t     dec,
  output logic                  flush,
  output logic                  done
);

  // ******************************************************************
  // Length, timing and class table
  // ******************************************************************
  function automatic cdt_pkg::cdt_info_t info_of(input logic [7:0] op);
    cdt_pkg::cdt_info_t r;
    r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_OTHER};
    casez (op)
      8'h00, cdt_pkg::OPC_SPARE_NOP: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_NOP};      // [RULE_14]
      end
      8'b???0_0001: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_JUMP};     // [RULE_09]
      end
      8'b???1_0001: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_CALL};     // [RULE_07]
      end
      8'h02, 8'h80: begin
        r = '{(op == 8'h02) ? cdt_pkg::LEN_3 : cdt_pkg::LEN_2,
              (op == 8'h02) ? cdt_pkg::CYC_4 : cdt_pkg::CYC_3,
              1'b0, cdt_pkg::CLS_JUMP};                                    // [RULE_09]
      end
      8'h73: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_JUMP};     // [RULE_09]
      end
      8'h12: begin
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_4, 1'b0, cdt_pkg::CLS_CALL};     // [RULE_07]
      end
      8'h22, 8'h32: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_5, 1'b0, cdt_pkg::CLS_RETURN};   // [RULE_08]
      end
      8'h40, 8'h50, 8'h60, 8'h70: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b1, cdt_pkg::CLS_CBRANCH};  // [RULE_03]
      end
      8'h10, 8'h20, 8'h30, 8'hB4, 8'hB5,
      8'b1011_1???, 8'hD5: begin                         // [RULE_04] [RULE_05] [RULE_06]
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_3, 1'b1, cdt_pkg::CLS_CBRANCH};
      end
      8'b1011_011?: begin
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_4, 1'b1, cdt_pkg::CLS_CBRANCH};  // [RULE_05]
      end
      8'b1101_1???: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b1, cdt_pkg::CLS_CBRANCH};  // [RULE_06]
      end
      8'h83, 8'h93: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_CODE_RD};  // [RULE_01]
      end
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_XDATA};    // [RULE_02]
      end
      8'h90: begin
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_DATA_POINTER_LD};  // [RULE_16]
      end
      8'hC0, 8'hD0: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_STACK};    // [RULE_17]
      end
      8'b1101_011?: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_NIBBLE};   // [RULE_18]
      end
      8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_ACC};      // [RULE_19]
      end
      8'hC3, 8'hD3, 8'hB3: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_CARRY};    // [RULE_20]
      end
      8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_BIT};      // [RULE_20]
      end
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_MOVE};     // [RULE_15]
      end
      8'b1110_011?, 8'b1111_011?, 8'b1100_011?: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_MOVE};     // [RULE_15]
      end
      8'h85, 8'h75: begin
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_MOVE};     // [RULE_15]
      end
      8'hE5, 8'h74, 8'hF5, 8'hC5, 8'b1010_1???, 8'b1000_1???, 8'b0111_1???,
      8'b1000_011?, 8'b1010_011?, 8'b0111_011?: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_MOVE};
      end
      8'h43, 8'h53, 8'h63: begin
        r = '{cdt_pkg::LEN_3, cdt_pkg::CYC_3, 1'b0, cdt_pkg::CLS_ACC};
      end
      8'h42, 8'h52, 8'h62, 8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65: begin
        r = '{cdt_pkg::LEN_2, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_ACC};
      end
      8'b0100_011?, 8'b0101_011?, 8'b0110_011?: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_2, 1'b0, cdt_pkg::CLS_ACC};
      end
      8'b0100_1???, 8'b0101_1???, 8'b0110_1???: begin
        r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_ACC};
      end
      // Opcodes outside this table decode as one byte and one cycle.
      default: r = '{cdt_pkg::LEN_1, cdt_pkg::CYC_1, 1'b0, cdt_pkg::CLS_OTHER};
    endcase
    return r;
  endfunction

  // Relative target: signed offset added to the next instruction address.
  function automatic logic [15:0] rel_target(input logic [15:0] nxt, input logic [7:0] off);
    return nxt + {{8{off[7]}}, off};                                       // [RULE_10]
  endfunction

  // Byte that holds a bit: low bit space lives in RAM, upper in SFR rows.
  function automatic logic [7:0] bit_home(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : (cdt_pkg::BIT_RAM_BASE + {4'h0, b[6:3]});
  endfunction

  // ******************************************************************
  // Combinational decode
  // ******************************************************************
  cdt_pkg::cdt_info_t info;
  cdt_pkg::cdt_dec_t  dec_c;
  logic [15:0]        next_pc;
  logic [7:0]         rhs;
  logic [7:0]         dec_res;
  logic [7:0]         op;

  always_comb begin
    op      = insn.opcode;
    info    = info_of(op);
    next_pc = insn.pc + {14'h0, info.len};
    rhs     = (op == 8'hB5) ? insn.direct_val : insn.op1;
    dec_res = insn.lhs_val - 8'h01;
    dec_c            = '0;
    dec_c.cls        = info.cls;
    dec_c.len        = info.len;
    dec_c.direct_sfr = (insn.op1 >= cdt_pkg::SFR_BASE);                    // [RULE_12]
    dec_c.bit_byte   = bit_home(insn.op1);
    dec_c.bit_pos    = insn.op1[2:0];
    // Register operands use the bank picked by the status word bits.
    if (op[3]) begin
      dec_c.reg_addr = {3'h0, insn.bank_sel, op[2:0]};                     // [RULE_13] [RULE_22]
      dec_c.reg_ok   = (op[7:4] != 4'h0) && (op[7:4] != 4'h1);
    end else if (op[3:1] == 3'b011) begin
      dec_c.reg_addr = {3'h0, insn.bank_sel, 2'h0, op[0]};                 // [RULE_13] [RULE_22]
      dec_c.reg_ok   = (op[7:4] >= 4'h2);
    end
    unique case (info.cls)
      cdt_pkg::CLS_JUMP, cdt_pkg::CLS_CALL: begin
        dec_c.target_ok = 1'b1;
        if (op[3:0] == 4'h1) begin
          dec_c.target = {next_pc[15:cdt_pkg::PAGE_BITS], op[7:5], insn.op1}; // [RULE_11]
        end else if (op == 8'h02 || op == 8'h12) begin
          dec_c.target = {insn.op1, insn.op2};                             // [RULE_21]
        end else if (op == 8'h80) begin
          dec_c.target = rel_target(next_pc, insn.op1);                    // [RULE_10]
        end else begin
          dec_c.target = insn.data_pointer + {8'h00, insn.acc};            // [RULE_09]
        end
      end
      cdt_pkg::CLS_CBRANCH: begin
        dec_c.target_ok = 1'b1;
        dec_c.target    = rel_target(next_pc, (info.len == cdt_pkg::LEN_2) ? insn.op1 : insn.op2);
        if (op[7:4] == 4'hD) begin
          dec_c.taken = (dec_res != 8'h00);                                // [RULE_06]
          dec_c.target = rel_target(next_pc,
                                    (info.len == cdt_pkg::LEN_2) ? insn.op1 : insn.op2);
        end else if (op[7:4] == 4'hB) begin
          dec_c.taken = ((op[3:0] == 4'h4 || op[3:0] == 4'h5) ? insn.acc : insn.lhs_val)
                        != rhs;                                            // [RULE_05]
        end else begin
          unique case (op)
            8'h40:   dec_c.taken = insn.carry;                             // [RULE_03]
            8'h50:   dec_c.taken = !insn.carry;                            // [RULE_03]
            8'h60:   dec_c.taken = (insn.acc == 8'h00);                    // [RULE_03]
            8'h70:   dec_c.taken = (insn.acc != 8'h00);                    // [RULE_03]
            8'h30:   dec_c.taken = !insn.bit_val;                          // [RULE_04]
            default: dec_c.taken = insn.bit_val;                           // [RULE_04]
          endcase
          dec_c.bit_clear = (op == 8'h10) && insn.bit_val;                 // [RULE_04]
        end
      end
      cdt_pkg::CLS_CODE_RD: begin
        dec_c.mem_addr = ((op == 8'h93) ? insn.data_pointer : next_pc)
                         + {8'h00, insn.acc};                              // [RULE_01]
      end
      cdt_pkg::CLS_XDATA: begin
        // Index forms carry the register in bit zero; their high byte is fixed.
        dec_c.mem_addr = op[1] ? {cdt_pkg::XDATA_PAGE_HI, insn.index_val}
                               : insn.data_pointer;                        // [RULE_02]
        dec_c.mem_wr   = op[4];                                            // [RULE_02]
      end
      cdt_pkg::CLS_DATA_POINTER_LD: begin
        dec_c.mem_addr = {insn.op1, insn.op2};                             // [RULE_16]
      end
      default: begin
        dec_c.target_ok = 1'b0;
      end
    endcase
    // A taken conditional branch costs exactly one more cycle.
    dec_c.cyc = info.cyc + {2'h0, (info.cond && dec_c.taken)};             // [RULE_03] [RULE_04]
  end

  // ******************************************************************
  // Cycle sequencer
  // ******************************************************************
  logic [2:0]        rem_r;
  logic [2:0]        rem_nxt;
  cdt_pkg::cdt_dec_t dec_r;
  cdt_pkg::cdt_dec_t dec_nxt;
  logic              flush_r;
  logic              flush_nxt;
  logic              accept;

  // The next instruction may be taken in the last cycle of the current one,
  // so a stream of single-cycle instructions runs one per clock.
  assign insn_ready = (rem_r <= cdt_pkg::CYC_1);
  assign accept     = insn_valid && insn_ready;
  assign done       = (rem_r == cdt_pkg::CYC_1);

  always_comb begin
    rem_nxt   = (rem_r == cdt_pkg::STATE_RESET) ? rem_r : rem_r - 3'h1;
    dec_nxt   = dec_r;
    flush_nxt = 1'b0;
    if (accept) begin
      rem_nxt   = dec_c.cyc;                                               // [RULE_15] [RULE_19]
      dec_nxt   = dec_c;
      // Drop the sequential prefetch before the target fetch begins.
      flush_nxt = dec_c.taken && (info.cls == cdt_pkg::CLS_CBRANCH);       // [RULE_23]
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rem_r   <= cdt_pkg::STATE_RESET;
      dec_r   <= '0;
      flush_r <= 1'b0;
    end else begin
      rem_r   <= rem_nxt;
      dec_r   <= dec_nxt;
      flush_r <= flush_nxt;
    end
  end

  assign dec   = dec_r;
  assign flush = flush_r;

endmodule

// file: hdl/cdt_pkg.sv
// Package of constants and carriers for the instruction decode and timing block.
package cdt_pkg;

  // ******************************************************************
  // Cycle counts and instruction lengths
  // ******************************************************************
  localparam logic [2:0] CYC_1          = 3'h1;
  localparam logic [2:0] CYC_2          = 3'h2;
  localparam logic [2:0] CYC_3          = 3'h3;
  localparam logic [2:0] CYC_4          = 3'h4;
  localparam logic [2:0] CYC_5          = 3'h5;
  localparam logic [1:0] LEN_1          = 2'h1;
  localparam logic [1:0] LEN_2          = 2'h2;
  localparam logic [1:0] LEN_3          = 2'h3;

  // ******************************************************************
  // Address layout, spare opcode and reset state
  // ******************************************************************
  localparam logic [7:0] OPC_SPARE_NOP  = 8'hA5;
  localparam logic [7:0] SFR_BASE       = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE   = 8'h20;
  localparam logic [7:0] XDATA_PAGE_HI  = 8'h00;
  localparam int         PAGE_BITS      = 11;
  localparam logic [2:0] STATE_RESET    = 3'h0;

  // ******************************************************************
  // Instruction classes
  // ******************************************************************
  typedef enum logic [3:0] {
    CLS_OTHER   = 4'h0,
    CLS_NOP     = 4'h1,
    CLS_ACC     = 4'h2,
    CLS_CARRY   = 4'h3,
    CLS_BIT     = 4'h4,
    CLS_MOVE    = 4'h5,
    CLS_CODE_RD = 4'h6,
    CLS_XDATA   = 4'h7,
    CLS_STACK   = 4'h8,
    CLS_DATA_POINTER_LD = 4'h9,
    CLS_JUMP    = 4'hA,
    CLS_CALL    = 4'hB,
    CLS_RETURN  = 4'hC,
    CLS_CBRANCH = 4'hD,
    CLS_NIBBLE  = 4'hE
  } cdt_class_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cyc;
    logic       cond;
    cdt_class_t cls;
  } cdt_info_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic        carry;
    logic [15:0] data_pointer;
    logic [1:0]  bank_sel;
    logic [7:0]  index_val;
    logic        bit_val;
    logic [7:0]  direct_val;
    logic [7:0]  lhs_val;
  } cdt_insn_t;

  typedef struct packed {
    cdt_class_t  cls;
    logic [1:0]  len;
    logic [2:0]  cyc;
    logic        taken;
    logic        target_ok;
    logic [15:0] target;
    logic [7:0]  reg_addr;
    logic        reg_ok;
    logic        direct_sfr;
    logic [7:0]  bit_byte;
    logic [2:0]  bit_pos;
    logic        bit_clear;
    logic [15:0] mem_addr;
    logic        mem_wr;
  } cdt_dec_t;

endpackage

// file: sim/cdt_decode_properties.sv
// Checker of cycle timing and branch targets for the decode block.
`timescale 1ns/100ps
module cdt_decode_properties (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               insn_valid,
  input wire cdt_pkg::cdt_insn_t insn,
  input wire logic               insn_ready,
  input wire cdt_pkg::cdt_dec_t  dec,
  input wire logic               flush,
  input wire logic               done
);
  // ********
  // Cycles since the last accept; saturates so an idle core never wraps.
  // ********
  logic       acc_w;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  assign acc_w = insn_valid & insn_ready;
  always_comb begin
    cnt_nxt = cnt_r;
    if (acc_w) begin
      cnt_nxt = 3'h1;
    end else if (cnt_r != 3'h0 && cnt_r != 3'h7) begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_nop; acc_w && insn.opcode == 8'hA5 |=> done && dec.cyc == 3'h1; endproperty
  a_nop: assert property (p_nop) else $error("spare opcode not one cycle");
  property p_cnt; done |-> cnt_r == dec.cyc && insn_ready; endproperty
  a_cnt: assert property (p_cnt) else $error("done off decoded count");
  property p_cond;
    acc_w && insn.opcode[3:0] == 4'h0 && insn.opcode[7:6] == 2'h1
      |=> dec.cyc == (dec.taken ? 3'h3 : 3'h2);
  endproperty
  a_cond: assert property (p_cond) else $error("short branch count wrong");
  property p_ret;
    acc_w && insn.opcode[7:5] == 3'h1 && insn.opcode[3:0] == 4'h2 |=> dec.cyc == 3'h5 ##4 done;
  endproperty
  a_ret: assert property (p_ret) else $error("return not five cycles");
  property p_long;
    acc_w && insn.opcode == 8'h02 |=> dec.target == {$past(insn.op1), $past(insn.op2)};
  endproperty
  a_long: assert property (p_long) else $error("long target wrong");
  property p_page;
    acc_w && insn.opcode[3:0] == 4'h1 |=> dec.target[10:0] == {$past(insn.opcode[7:5]),
      $past(insn.op1)} && dec.target[15:11] == $past(insn.pc[15:11] + 5'(insn.pc[10:0] > 11'h7FD));
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_rel;
    acc_w && insn.opcode == 8'h80
      |=> dec.target == $past(insn.pc + 16'h0002 + {{8{insn.op1[7]}}, insn.op1});
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_flush; acc_w |=> flush == (dec.taken && dec.cls == cdt_pkg::CLS_CBRANCH); endproperty
  a_flush: assert property (p_flush) else $error("flush not tied to taken branch");
  c_flush: cover property (flush);
  c_ret: cover property (acc_w && insn.opcode == 8'h22);
  c_four: cover property (done && dec.cyc == 3'h4);
endmodule

bind cdt_decode cdt_decode_properties u_chk (.sys_clk(sys_clk), .reset(reset),
  .insn_valid(insn_valid), .insn(insn), .insn_ready(insn_ready), .dec(dec), .flush(flush),
  .done(done));

// file: sim/cdt_decode_test.sv
// Self-checking bench for the decode and timing block.
`timescale 1ns/100ps
module cdt_decode_test;
  logic               sys_clk;
  logic               reset;
  logic               insn_valid;
  logic               insn_ready;
  logic               flush;
  logic               done;
  cdt_pkg::cdt_insn_t insn;
  cdt_pkg::cdt_dec_t  dec;
  logic [7:0]         op_r, o1_r, o2_r, acc_r, idx_w, dir_w, lhs_w;
  logic [15:0]        pc_r;
  logic [1:0]         bank_r;
  logic               cy_r, bit_r;
  int                 error_cnt = 0;
  int                 n_tests = 0;
  int                 cyc_cnt = 0;
  assign insn = {op_r, o1_r, o2_r, pc_r, acc_r, cy_r, 16'h1234, bank_r, idx_w, bit_r, dir_w, lhs_w};
  cdt_decode u_dut (.sys_clk(sys_clk), .reset(reset), .insn_valid(insn_valid), .insn(insn),
    .insn_ready(insn_ready), .dec(dec), .flush(flush), .done(done));
  cdt_ram_model u_ram (.opcode(op_r), .op1(o1_r), .bank_sel(bank_r), .index_val(idx_w),
    .direct_val(dir_w), .lhs_val(lhs_w));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One instruction; tk[1] enables the taken and flush check, tk[0] is the expectation.
  task automatic exec(input logic [7:0] op, o1, o2, input logic [2:0] cyc, input logic [1:0] len,
                      input logic [1:0] tk);
    int n;
    @(negedge sys_clk);
    op_r       = op;
    o1_r       = o1;
    o2_r       = o2;
    insn_valid = 1'b1;
    chk({15'h0, insn_ready}, 16'h0001);
    @(negedge sys_clk);
    insn_valid = 1'b0;
    chk({13'h0, dec.cyc}, {13'h0, cyc});
    chk({15'h0, insn_ready}, {15'h0, cyc == 3'h1});
    chk({14'h0, dec.len}, {14'h0, len});
    if (tk[1]) begin
      chk({14'h0, dec.taken, flush}, {14'h0, tk[0], tk[0]});
    end
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(n), {13'h0, cyc});
  endtask
  // Table entries are opcode, length nibble and cycle nibble.
  task automatic t_fixed();
    logic [15:0] tbl [37] = '{16'hE411, 16'hF411, 16'hC411, 16'h2311, 16'h3311, 16'h0311,
      16'h1311, 16'hC311, 16'hD311, 16'hB311, 16'hA511, 16'h0011, 16'hE811, 16'hC022,
      16'hD022, 16'hD612, 16'h8222, 16'hA022, 16'hA222, 16'h9222, 16'hE612, 16'h9313,
      16'h8313, 16'hE013, 16'hE213, 16'hF013, 16'hF213, 16'h9033, 16'h8533, 16'h1123,
      16'h1234, 16'h2215, 16'h3215, 16'h0123, 16'h0234, 16'h8023, 16'h7313};
    foreach (tbl[i]) begin
      exec(tbl[i][15:8], 8'h12, 8'h34, tbl[i][2:0], tbl[i][5:4], 2'b00);
    end
  endtask
  task automatic t_branch();
    cy_r = 1'b1;
    exec(8'h40, 8'h10, 8'h00, 3'h3, 2'h2, 2'b11);
    exec(8'h50, 8'h10, 8'h00, 3'h2, 2'h2, 2'b10);
    acc_r = 8'h00;
    exec(8'h60, 8'h10, 8'h00, 3'h3, 2'h2, 2'b11);
    exec(8'h70, 8'h10, 8'h00, 3'h2, 2'h2, 2'b10);
    bit_r = 1'b1;
    exec(8'h20, 8'h20, 8'h10, 3'h4, 2'h3, 2'b11);
    exec(8'h30, 8'h20, 8'h10, 3'h3, 2'h3, 2'b10);
    exec(8'h10, 8'h20, 8'h10, 3'h4, 2'h3, 2'b11);
    chk({15'h0, dec.bit_clear}, 16'h0001);
    chk({dec.bit_byte, 5'h00, dec.bit_pos}, 16'h2400);
    acc_r = 8'h05;
    exec(8'hB4, 8'h05, 8'h10, 3'h3, 2'h3, 2'b10);
    exec(8'hB4, 8'h06, 8'h10, 3'h4, 2'h3, 2'b11);
    exec(8'hB5, 8'h5F, 8'h10, 3'h3, 2'h3, 2'b10);
    exec(8'hB6, 8'h08, 8'h10, 3'h4, 2'h3, 2'b10);
    exec(8'hB6, 8'h09, 8'h10, 3'h5, 2'h3, 2'b11);
    exec(8'hD8, 8'h10, 8'h00, 3'h3, 2'h2, 2'b11);
    exec(8'hD5, 8'h5B, 8'h10, 3'h3, 2'h3, 2'b10);
    exec(8'hD5, 8'h10, 8'h20, 3'h4, 2'h3, 2'b11);
  endtask
  task automatic t_target();
    pc_r = 16'h0100;
    exec(8'h80, 8'hFE, 8'h00, 3'h3, 2'h2, 2'b00);
    chk(dec.target, 16'h0100);
    exec(8'h80, 8'h7F, 8'h00, 3'h3, 2'h2, 2'b00);
    chk(dec.target, 16'h0181);
    pc_r = 16'h07FE;
    exec(8'hE1, 8'h34, 8'h00, 3'h3, 2'h2, 2'b00);
    chk(dec.target, 16'h0F34);
    exec(8'h02, 8'h1D, 8'hFF, 3'h4, 2'h3, 2'b00);
    chk(dec.target, 16'h1DFF);
    exec(8'h83, 8'h00, 8'h00, 3'h3, 2'h1, 2'b00);
    chk(dec.mem_addr, 16'h0804);
    exec(8'h93, 8'h00, 8'h00, 3'h3, 2'h1, 2'b00);
    chk(dec.mem_addr, 16'h1239);
    exec(8'h90, 8'hAB, 8'hCD, 3'h3, 2'h3, 2'b00);
    chk(dec.mem_addr, 16'hABCD);
    exec(8'hE2, 8'h00, 8'h00, 3'h3, 2'h1, 2'b00);
    chk(dec.mem_addr, 16'h0052);
    exec(8'hF0, 8'h00, 8'h00, 3'h3, 2'h1, 2'b00);
    chk({dec.mem_addr[14:0], dec.mem_wr}, {15'h1234, 1'b1});
    exec(8'hC0, 8'h81, 8'h00, 3'h2, 2'h2, 2'b00);
    chk({15'h0, dec.direct_sfr}, 16'h0001);
    exec(8'hC0, 8'h7F, 8'h00, 3'h2, 2'h2, 2'b00);
    chk({15'h0, dec.direct_sfr}, 16'h0000);
    bank_r = 2'h2;
    exec(8'hDB, 8'h10, 8'h00, 3'h3, 2'h2, 2'b11);
    chk({8'h00, dec.reg_addr}, 16'h0013);
  endtask
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      $display("Error at %0t: cycles %h limit %h", $time, cyc_cnt, 3000);
      final_report();
    end
  end
  initial begin
    sys_clk    = 1'b0;
    reset      = 1'b1;
    insn_valid = 1'b0;
    {op_r, o1_r, o2_r, acc_r, cy_r, bit_r} = '0;
    pc_r       = 16'h0100;
    bank_r     = 2'h1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    t_fixed();
    $display("Test fixed timing ended");
    t_branch();
    $display("Test conditional branches ended");
    t_target();
    $display("Test targets and addressing ended");
    final_report();
  end
endmodule

// file: sim/cdt_ram_model.sv
// Behavioural data RAM that supplies operand values to the decoder.
`timescale 1ns/100ps
module cdt_ram_model (
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] op1,
  input  wire logic [1:0] bank_sel,
  output logic      [7:0] index_val,
  output logic      [7:0] direct_val,
  output logic      [7:0] lhs_val
);
  // ********
  // Each byte holds its address XOR 0x5A, so no two places read alike.
  // ********
  always_comb begin
    index_val  = {3'h0, bank_sel, 2'h0, opcode[0]} ^ 8'h5A;
    direct_val = op1 ^ 8'h5A;
    if (opcode[3:1] == 3'h3) begin
      lhs_val = index_val ^ 8'h5A;
    end else if (opcode[3:0] == 4'h5) begin
      lhs_val = direct_val;
    end else begin
      lhs_val = {3'h0, bank_sel, opcode[2:0]} ^ 8'h5A;
    end
  end
endmodule
